// File: ast_transmitter.sv
`timescale 1ns/100ps
module ast_transmitter (
  // clock, reset and clock enable
  input  wire logic                    CLK,
  input  wire logic                    RESETN,
  input  wire logic                    CE,
  // configuration shared with the receiver
  input  wire ast_pkg::ast_config_type CONFIG,
  // character write port
  input  wire logic                    WRITE_STROBE,
  input  wire ast_pkg::ast_char_type   WRITE_CHAR,
  input  wire logic                    SEND_BREAK,
  output logic                         WRITE_READY,
  // status
  output logic                         TRANSMIT_BUFFER_EMPTY_FLAG,
  output logic                         SHIFT_REGISTER_EMPTY,
  // serial output
  output ast_pkg::ast_serial_type      SERIAL
);
  import ast_pkg::*;

  typedef struct packed {
    ast_state_type  state;
    logic [8:0]     shift;
    logic [3:0]     bits_left;
    logic [15:0]    baud_cnt;
    logic           hold_valid;
    ast_char_type   hold_char;
    logic           hold_break;
    logic           line;
    logic           tbe_flag;
    logic           sr_empty;
    ast_serial_type serial;
  } ast_tx_state_type;

  ast_tx_state_type s_reg;
  ast_tx_state_type s_next;

  // write port into the fifo: break requests ride along as a tenth bit
  logic        fifo_in_valid;
  logic [9:0]  fifo_in_data;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [9:0]  fifo_out_data;
  logic        fifo_out_ready;
  logic        tx_active;
  logic        bit_done;
  logic        out_level;

  // reload value for one bit period, divider interval is reload plus one
  function automatic logic [15:0] bit_reload(input ast_config_type cfg);
    if (cfg.divider_16bit_select) begin
      bit_reload = cfg.baud_divider;
    end else begin
      bit_reload = {8'h00, cfg.baud_divider[7:0]};
    end
  endfunction

  // number of data bits for a frame about to be loaded
  function automatic logic [3:0] frame_bits(input logic brk, input logic nine);
    if (brk) begin
      frame_bits = BITS_BREAK;
    end else if (nine) begin
      frame_bits = BITS_NINE;
    end else begin
      frame_bits = BITS_EIGHT;
    end
  endfunction

  // ninth bit sampled at the low byte write, never later
  assign fifo_in_valid = WRITE_STROBE;
  assign fifo_in_data  = {SEND_BREAK, WRITE_CHAR};

  // holding buffer drains the fifo only while it is free
  assign fifo_out_ready = !s_reg.hold_valid && tx_active;

  ast_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH)
  ) ast_fifo_inst (
    .clk       (CLK),
    .resetn    (RESETN),
    .ce        (CE),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  assign WRITE_READY = fifo_in_ready;

  // same format and rate bits as the receiver, no private copy here
  assign tx_active = CONFIG.transmit_enable && CONFIG.serial_port_enable
                     && !CONFIG.clocked_mode_select;

  assign bit_done = (s_reg.baud_cnt == BAUD_CNT_RST);

  always_comb begin
    s_next    = s_reg;
    out_level = MARK_LEVEL;

    // holding buffer fills from the fifo
    if (fifo_out_ready && fifo_out_valid) begin
      s_next.hold_valid = 1'b1;
      s_next.hold_char  = ast_char_type'(fifo_out_data[8:0]);
      s_next.hold_break = fifo_out_data[9];
    end

    unique case (s_reg.state)
      ST_IDLE: begin
        s_next.line = MARK_LEVEL;
        if (s_reg.hold_valid) begin
          // empty shift register takes the character at once
          s_next.state      = ST_START;
          s_next.shift      = s_reg.hold_break ? CHAR_RST : s_reg.hold_char;
          s_next.bits_left  = frame_bits(s_reg.hold_break,
                                         CONFIG.nine_bit_char_select);
          s_next.baud_cnt   = bit_reload(CONFIG);
          s_next.hold_valid = 1'b0;
          s_next.line       = SPACE_LEVEL;
        end
      end
      ST_START: begin
        s_next.line = SPACE_LEVEL;
        if (bit_done) begin
          s_next.state    = ST_DATA;
          s_next.baud_cnt = bit_reload(CONFIG);
          s_next.line     = s_reg.shift[0];
        end else begin
          s_next.baud_cnt = 16'(s_reg.baud_cnt - 1'b1);
        end
      end
      ST_DATA: begin
        // level held for the whole bit, no return between equal bits
        s_next.line = s_reg.shift[0];
        if (bit_done) begin
          s_next.baud_cnt  = bit_reload(CONFIG);
          s_next.shift     = {1'b0, s_reg.shift[8:1]};
          s_next.bits_left = 4'(s_reg.bits_left - 1'b1);
          if (s_reg.bits_left == 4'h1) begin
            s_next.state = ST_STOP;
            s_next.line  = MARK_LEVEL;
          end else begin
            s_next.line = s_reg.shift[1];
          end
        end else begin
          s_next.baud_cnt = 16'(s_reg.baud_cnt - 1'b1);
        end
      end
      ST_STOP: begin
        s_next.line = MARK_LEVEL;
        if (bit_done) begin
          if (s_reg.hold_valid) begin
            // waiting character moves in the cycle the stop bit ends
            s_next.state      = ST_START;
            s_next.shift      = s_reg.hold_break ? CHAR_RST : s_reg.hold_char;
            s_next.bits_left  = frame_bits(s_reg.hold_break,
                                           CONFIG.nine_bit_char_select);
            s_next.baud_cnt   = bit_reload(CONFIG);
            s_next.hold_valid = 1'b0;
            s_next.line       = SPACE_LEVEL;
          end else begin
            s_next.state = ST_IDLE;
          end
        end else begin
          s_next.baud_cnt = 16'(s_reg.baud_cnt - 1'b1);
        end
      end
    endcase

    // losing an enable abandons the frame and the held character
    if (!tx_active) begin
      s_next.state      = ST_IDLE;
      s_next.line       = MARK_LEVEL;
      s_next.hold_valid = 1'b0;
      s_next.baud_cnt   = BAUD_CNT_RST;
      s_next.bits_left  = CNT_RST;
    end

    // shift register counts as busy from load until the stop bit ends
    s_next.sr_empty = (s_next.state == ST_IDLE);

    // flag follows enable and an empty path, no software write exists
    s_next.tbe_flag = CONFIG.transmit_enable && !s_next.hold_valid
                      && !fifo_out_valid;

    // inversion is an async-only feature; clocked mode keeps plain levels
    if (CONFIG.clocked_mode_select) begin
      out_level = s_next.line;
    end else begin
      out_level = s_next.line ^ CONFIG.transmit_invert_select;
    end

    // no parity logic: the ninth bit is shifted exactly as written
    s_next.serial.pin_out    = out_level;
    s_next.serial.pin_oe     = CONFIG.serial_port_enable;
    s_next.serial.logic_cell = out_level;
    s_next.serial.modulator  = out_level;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_reg <= '{
        state:      ST_IDLE,
        shift:      CHAR_RST,
        bits_left:  CNT_RST,
        baud_cnt:   BAUD_CNT_RST,
        hold_valid: FLAG_RST,
        hold_char:  CHAR_RST,
        hold_break: FLAG_RST,
        line:       MARK_LEVEL,
        tbe_flag:   FLAG_RST,
        sr_empty:   EMPTY_RST,
        serial:     '{pin_out: MARK_LEVEL, pin_oe: FLAG_RST,
                      logic_cell: MARK_LEVEL, modulator: MARK_LEVEL}
      };
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // all outputs straight from the state flops
  assign TRANSMIT_BUFFER_EMPTY_FLAG = s_reg.tbe_flag;
  assign SHIFT_REGISTER_EMPTY       = s_reg.sr_empty;
  assign SERIAL                     = s_reg.serial;

endmodule

// File: ast_pkg.sv
package ast_pkg;

  // character, divider and counter widths and fifo depth
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CHAR_W       = 9;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned DIV_W        = 16;
  localparam int unsigned CNT_W        = 4;

  // line levels before polarity is applied
  localparam logic        MARK_LEVEL   = 1'h1;
  localparam logic        SPACE_LEVEL  = 1'h0;

  // data bits per frame
  localparam logic [3:0]  BITS_EIGHT   = 4'h8;
  localparam logic [3:0]  BITS_NINE    = 4'h9;
  // break: start bit plus twelve space bits gives thirteen bit times low
  localparam logic [3:0]  BITS_BREAK   = 4'hC;

  // reset values
  localparam logic [15:0] BAUD_CNT_RST = 16'h0000;
  localparam logic [8:0]  CHAR_RST     = 9'h000;
  localparam logic [3:0]  CNT_RST      = 4'h0;
  localparam logic        FLAG_RST     = 1'h0;
  localparam logic        EMPTY_RST    = 1'h1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP
  } ast_state_type;

  // one character as written: ninth bit travels with the low byte
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ast_char_type;

  // static configuration and enables
  typedef struct packed {
    logic        transmit_enable;
    logic        serial_port_enable;
    logic        clocked_mode_select;
    logic        nine_bit_char_select;
    logic        transmit_invert_select;
    logic        divider_16bit_select;
    logic [15:0] baud_divider;
  } ast_config_type;

  // serial output group
  typedef struct packed {
    logic pin_out;
    logic pin_oe;
    logic logic_cell;
    logic modulator;
  } ast_serial_type;

endpackage

// File: ast_fifo.sv
`timescale 1ns/100ps
module ast_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int unsigned PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
    logic             ready;
  } ast_fifo_state_type;

  logic [WIDTH-1:0]   mem [DEPTH];
  ast_fifo_state_type s_reg;
  ast_fifo_state_type s_next;
  logic               push;
  logic               pop;

  // ready is a flop so the filling side sees a clean level
  assign in_ready  = s_reg.ready;
  assign out_valid = (s_reg.count != '0);
  assign out_data  = mem[s_reg.rd_ptr];
  assign push      = in_valid && s_reg.ready;
  assign pop       = out_ready && out_valid;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wr_ptr = PTR_W'(s_reg.wr_ptr + 1'b1);
    end
    if (pop) begin
      s_next.rd_ptr = PTR_W'(s_reg.rd_ptr + 1'b1);
    end
    s_next.count = (PTR_W+1)'(s_reg.count + push - pop);
    s_next.ready = (s_next.count != (PTR_W+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{wr_ptr: '0, rd_ptr: '0, count: '0, ready: 1'b1};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // storage has no reset, only written on push
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[s_reg.wr_ptr] <= in_data;
    end
  end

endmodule

// File: ast_transmitter_checker.sv
`timescale 1ns/100ps
module ast_transmitter_checker (
  // clock and reset
  input wire logic                    CLK,
  input wire logic                    RESETN,
  input wire logic                    CE,
  // watched ports
  input wire ast_pkg::ast_config_type CONFIG,
  input wire logic                    TRANSMIT_BUFFER_EMPTY_FLAG,
  input wire logic                    SHIFT_REGISTER_EMPTY,
  input wire ast_pkg::ast_serial_type SERIAL
);
  import ast_pkg::*;
  logic act;
  logic mark;
  assign act = CE && CONFIG.transmit_enable && CONFIG.serial_port_enable
             && !CONFIG.clocked_mode_select;
  // clocked mode idles at plain mark, no inversion
  assign mark = MARK_LEVEL ^ (CONFIG.transmit_invert_select && !CONFIG.clocked_mode_select);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_quiet;
    SHIFT_REGISTER_EMPTY && $past(SHIFT_REGISTER_EMPTY) && $past(RESETN) && $stable(CONFIG);
  endsequence
  sequence s_load;
    $fell(SHIFT_REGISTER_EMPTY) && act;
  endsequence
  // abort settled two edges after the enable drops
  sequence s_drop;
    (CE && $fell(CONFIG.transmit_enable) && !CONFIG.clocked_mode_select
      && $stable(CONFIG.transmit_invert_select)) ##1 (CE && $stable(CONFIG))[*2];
  endsequence
  AST_IDLE_MARK: assert property (s_quiet |-> SERIAL.pin_out == mark)
    else $error("line not at mark while idle");
  AST_START_SPACE: assert property (
    s_load |-> SERIAL.pin_out == (SPACE_LEVEL ^ CONFIG.transmit_invert_select))
    else $error("start bit not space at load");
  AST_PIN_DIR: assert property (
    CE && $changed(CONFIG.serial_port_enable)
      |=> SERIAL.pin_oe == $past(CONFIG.serial_port_enable))
    else $error("pin direction does not follow port enable");
  AST_TAPS: assert property (
    SERIAL.logic_cell == SERIAL.pin_out && SERIAL.modulator == SERIAL.pin_out)
    else $error("internal taps differ from pin");
  AST_FLAG_EN: assert property (
    TRANSMIT_BUFFER_EMPTY_FLAG && $past(CE) |-> $past(CONFIG.transmit_enable))
    else $error("buffer empty flag without transmit enable");
  AST_BUSY_HOLD: assert property (s_load ##1 act[*7] |-> !SHIFT_REGISTER_EMPTY)
    else $error("shift register empty in mid frame");
  AST_NO_SEND: assert property ((CE && !act)[*3] |-> SHIFT_REGISTER_EMPTY)
    else $error("shifting while not enabled");
  AST_ABORT_MARK: assert property (s_drop |-> SERIAL.pin_out == mark)
    else $error("line not back at mark after enable dropped");
endmodule

bind ast_transmitter ast_transmitter_checker ast_transmitter_checker_inst (
  .CLK(CLK), .RESETN(RESETN), .CE(CE), .CONFIG(CONFIG),
  .TRANSMIT_BUFFER_EMPTY_FLAG(TRANSMIT_BUFFER_EMPTY_FLAG),
  .SHIFT_REGISTER_EMPTY(SHIFT_REGISTER_EMPTY), .SERIAL(SERIAL));

// File: ast_remote_rx.sv
`timescale 1ns/100ps
module ast_remote_rx (
  // line side
  input wire logic        clk,
  input wire logic        line,
  input wire logic        listen,
  // same format and rate as the transmitter
  input wire logic        invert,
  input wire logic        nine,
  input wire logic [15:0] divider
);
  logic [9:0] got [$];
  logic [9:0] w;
  int         i;
  // samples mid bit; holds {stop, ninth, data} per frame
  initial begin
    forever begin
      @(posedge clk);
      if (listen && (line ^ invert) === 1'b0) begin
        repeat ((divider + 1) / 2) @(posedge clk);
        w = '0;
        for (i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (divider + 1) @(posedge clk);
          w[i] = line ^ invert;
        end
        repeat (divider + 1) @(posedge clk);
        w[9] = line ^ invert;
        got.push_back(w);
        // a bad stop would misframe the next start
        while ((line ^ invert) !== 1'b1) @(posedge clk);
      end
    end
  end
endmodule

// File: ast_transmitter_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module ast_transmitter_tb;
  import ast_pkg::*;
  typedef struct packed {
    logic        nine;
    logic        inv;
    logic        s16;
    logic [15:0] dv;
    logic [8:0]  ch;
    logic [15:0] d;
  } ast_row_type;
  logic           clk;
  logic           resetn;
  logic           ce;
  logic           strobe;
  logic           brk;
  logic           ready;
  logic           tbe;
  logic           sre;
  logic           listen;
  logic           rx_inv;
  logic           rx_nine;
  logic           saw_full = 1'b0;
  logic [15:0]    rx_div;
  ast_char_type   wchar;
  ast_config_type cfg;
  ast_serial_type ser;
  int             errors = 0;
  int             total_checks = 0;
  int             lo_run = 0;
  int             lo_last = 0;
  int             busy_run = 0;
  int             busy_max = 0;
  ast_row_type    rows [4] = '{
    '{1'b0, 1'b0, 1'b0, 16'h0002, 9'h1A5, 16'h0002},
    '{1'b1, 1'b0, 1'b0, 16'h0103, 9'h13C, 16'h0003},
    '{1'b0, 1'b1, 1'b0, 16'h0001, 9'h081, 16'h0001},
    '{1'b1, 1'b1, 1'b1, 16'h0102, 9'h0C3, 16'h0102}};

  ast_transmitter ast_transmitter_inst (
    .CLK(clk), .RESETN(resetn), .CE(ce), .CONFIG(cfg), .WRITE_STROBE(strobe),
    .WRITE_CHAR(wchar), .SEND_BREAK(brk), .WRITE_READY(ready),
    .TRANSMIT_BUFFER_EMPTY_FLAG(tbe), .SHIFT_REGISTER_EMPTY(sre), .SERIAL(ser));
  ast_remote_rx ast_remote_rx_inst (
    .clk(clk), .line(ser.pin_out), .listen(listen), .invert(rx_inv), .nine(rx_nine),
    .divider(rx_div));

  always @(posedge clk) begin
    lo_run <= (ser.pin_out === 1'b0) ? lo_run + 1 : 0;
    if (ser.pin_out === 1'b1 && lo_run != 0) begin
      lo_last <= lo_run;
    end
    busy_run <= (sre === 1'b0) ? busy_run + 1 : 0;
    busy_max <= (busy_run > busy_max) ? busy_run : busy_max;
    saw_full <= saw_full | (ready === 1'b0);
  end

  task automatic report_and_stop;
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // two idle edges after a write so a late ready drop is never raced
  task automatic put(input logic [8:0] c, input logic b);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    strobe <= 1'b1;
    wchar <= c;
    brk <= b;
    @(posedge clk);
    strobe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic expect_rx(input logic [9:0] w);
    logic [9:0] seen;
    int         n;
    seen = 'x;
    n = 0;
    while (ast_remote_rx_inst.got.size() == 0 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (ast_remote_rx_inst.got.size() != 0) begin
      seen = ast_remote_rx_inst.got.pop_front();
    end
    `CHK("received frame", w, seen)
  endtask

  // receiver deaf while polarity settles, else a false start
  task automatic set_fmt(input ast_row_type r);
    int n;
    n = 0;
    // format changes only between frames, never under a stop bit
    while (sre !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    listen <= 1'b0;
    cfg.nine_bit_char_select <= r.nine;
    cfg.transmit_invert_select <= r.inv;
    cfg.divider_16bit_select <= r.s16;
    cfg.baud_divider <= r.dv;
    repeat (4) @(posedge clk);
    rx_inv <= r.inv;
    rx_nine <= r.nine;
    rx_div <= r.d;
    listen <= 1'b1;
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    strobe = 1'b0;
    brk = 1'b0;
    wchar = '0;
    cfg = '0;
    listen = 1'b0;
    rx_inv = 1'b0;
    rx_nine = 1'b0;
    rx_div = 16'h0002;
    repeat (2) @(posedge clk);
    `CHK("reset state", 7'h5B, {ready, tbe, sre, ser})
    resetn <= 1'b1;
    @(posedge clk);
    cfg.serial_port_enable <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("pin dir and flag", 2'h2, {ser.pin_oe, tbe})
    cfg.transmit_enable <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("flag after enable", 1'b1, tbe)
    set_fmt('{1'b0, 1'b0, 1'b0, 16'h0001, 9'h000, 16'h0001});
    for (int k = 0; k < 6; k++) begin
      put(9'h030 + 9'(k), 1'b0);
    end
    // queue full here: this strobe must be dropped
    strobe <= 1'b1;
    wchar <= 9'h0FF;
    @(posedge clk);
    strobe <= 1'b0;
    `CHK("queued flags", 2'h0, {tbe, sre})
    for (int k = 0; k < 6; k++) begin
      expect_rx(10'h230 + 10'(k));
    end
    repeat (4) @(posedge clk);
    `CHK("frames joined", 1'b1, busy_max > 100)
    `CHK("queue refused", 1'b1, saw_full)
    `CHK("drained", 3'h7, {ready, tbe, sre})
    foreach (rows[i]) begin
      set_fmt(rows[i]);
      put(rows[i].ch, 1'b0);
      expect_rx({1'b1, rows[i].nine & rows[i].ch[8], rows[i].ch[7:0]});
    end
    set_fmt('{1'b0, 1'b0, 1'b0, 16'h0002, 9'h000, 16'h0002});
    listen <= 1'b0;
    put(9'h0FF, 1'b1);
    repeat (50) @(posedge clk);
    `CHK("break length", 39, lo_last)
    cfg.baud_divider <= 16'h0003;
    put(9'h000, 1'b0);
    repeat (12) @(posedge clk);
    cfg.transmit_enable <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("line after abort", 3'h6, {ser.pin_out, sre, tbe})
    cfg.transmit_invert_select <= 1'b1;
    cfg.clocked_mode_select <= 1'b1;
    cfg.transmit_enable <= 1'b1;
    put(9'h05A, 1'b0);
    repeat (20) @(posedge clk);
    `CHK("clocked mode quiet", 2'h3, {sre, ser.pin_out})
    cfg.transmit_invert_select <= 1'b0;
    repeat (3) @(posedge clk);
    rx_div <= 16'h0003;
    listen <= 1'b1;
    @(posedge clk);
    cfg.clocked_mode_select <= 1'b0;
    expect_rx(10'h25A);
    listen <= 1'b0;
    while (sre !== 1'b1) @(posedge clk);
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    put(9'h0FF, 1'b0);
    `CHK("frozen write", 3'h7, {ready, tbe, sre})
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("write lost while frozen", 2'h3, {tbe, sre})
    put(9'h000, 1'b0);
    repeat (12) @(posedge clk);
    cfg.serial_port_enable <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("port enable abort", 3'h5, {ser.pin_out, ser.pin_oe, sre})
    cfg.serial_port_enable <= 1'b1;
    put(9'h0C3, 1'b0);
    repeat (6) @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    `CHK("mid-run reset", 7'h5B, {ready, tbe, sre, ser})
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("after reset", 4'hF, {tbe, sre, ser.pin_out, ser.pin_oe})
    listen <= 1'b1;
    put(9'h03C, 1'b0);
    expect_rx(10'h23C);
    report_and_stop();
  end
endmodule
